// *** cfb8_byte_stream_wrapper.sv ***
// module: byte cipher feedback wrapper around a 64-bit block cipher engine
//
// Contract
// - the eight byte shift buffer is filled with arbitrary bytes before any text byte is taken.
// - when sending, one byte of the enciphered buffer becomes the current key byte.
// - when sending, each cipher byte is the plain byte XOR the key byte.
// - when sending, the cipher byte enters as newest buffer byte, the oldest drops, then it is output.
// - when sending, the new buffer goes to the engine and gives the next key byte.
// - when receiving, each plain byte is the cipher byte XOR the engine key byte.
// - when receiving, each cipher byte enters as newest buffer byte and the oldest drops.
// - when receiving, the updated buffer is then handed to the engine for block processing.
// - when receiving, one byte read from the engine data after processing keys the next byte.
// - exactly one byte is moved per engine block operation, or per three engine operations with triple pass.
// - optionally three passes alternate the operation using a pair of keys.
// - optionally the engine operation is reversed, mirrored at the far end.
// - an engine operation takes 320 double rate clock cycles and busy holds until done.
// - the data register reads zero before completion and each byte read shifts zeros in.
`timescale 1ns/1ps
module cfb8_byte_stream_wrapper (
   // clock and reset
   input  wire logic                     sys_clk_i,
   input  wire logic                     rstn_i,
   // configuration, caught with first fill byte
   input  wire logic                     dir_decipher_i,
   input  wire logic                     op_reverse_i,
   input  wire logic                     triple_pass_i,
   // host byte input
   input  wire logic                     in_valid_i,
   input  wire cfb8_pkg::byte_in_t       in_byte_i,
   output logic                          in_ready_o,
   // host byte output
   output logic                          out_valid_o,
   output logic [cfb8_pkg::BYTE_W-1:0]   out_byte_o,
   input  wire logic                     out_ready_i,
   // block cipher engine
   output cfb8_pkg::eng_req_t            eng_req_o,
   input  wire logic                     eng_done_i,
   input  wire logic [cfb8_pkg::BLOCK_W-1:0] eng_result_i,
   // status
   output logic                          busy_o,
   output logic                          fill_done_o
);
   // ****************************************
   // state
   // ****************************************
   cfb8_pkg::state_t                 state_r, state_nxt;
   logic [cfb8_pkg::BLOCK_W-1:0]     shift_r, shift_nxt;
   logic [cfb8_pkg::BLOCK_W-1:0]     dreg_r, dreg_nxt;
   logic [cfb8_pkg::BYTE_W-1:0]      key_r, key_nxt;
   logic [3:0]                       fill_cnt_r, fill_cnt_nxt;
   logic [1:0]                       pass_r, pass_nxt;
   logic                             dec_r, dec_nxt;
   logic                             rev_r, rev_nxt;
   logic                             tri_r, tri_nxt;
   logic                             done_seen_r, done_seen_nxt;
   cfb8_pkg::eng_req_t               req_r, req_nxt;
   logic                             take, push_ready, push_valid;
   logic [cfb8_pkg::BYTE_W-1:0]      push_data, feedback;

   // new byte enters at the low end, oldest leaves at the top
   function automatic logic [cfb8_pkg::BLOCK_W-1:0] shift_in(
      input logic [cfb8_pkg::BLOCK_W-1:0] blk,
      input logic [cfb8_pkg::BYTE_W-1:0]  b);
      shift_in = {blk[cfb8_pkg::BLOCK_W-cfb8_pkg::BYTE_W-1:0], b};
   endfunction

   // ****************************************
   // input handshake and byte path
   // ****************************************
   // fill bytes accepted any time in fill; text only with a key and room
   assign in_ready_o  = (state_r == cfb8_pkg::ST_FILL) ||
                        ((state_r == cfb8_pkg::ST_BYTE) && push_ready);
   assign take        = in_valid_i && in_ready_o;
   assign push_data   = in_byte_i.data ^ key_r;
   assign push_valid  = take && (state_r == cfb8_pkg::ST_BYTE) && !in_byte_i.is_fill;
   // cipher byte is fed back: output when sending, input when receiving
   assign feedback    = dec_r ? in_byte_i.data : push_data;
   assign busy_o      = (state_r == cfb8_pkg::ST_RUN) || (state_r == cfb8_pkg::ST_WAIT);
   assign fill_done_o = (fill_cnt_r == cfb8_pkg::FILL_BYTES);
   assign eng_req_o   = req_r;

   // next state of the sequencer
   always_comb begin
      state_nxt     = state_r;
      shift_nxt     = shift_r;
      dreg_nxt      = dreg_r;
      key_nxt       = key_r;
      fill_cnt_nxt  = fill_cnt_r;
      pass_nxt      = pass_r;
      dec_nxt       = dec_r;
      rev_nxt       = rev_r;
      tri_nxt       = tri_r;
      done_seen_nxt = done_seen_r;
      req_nxt       = req_r;
      req_nxt.start = 1'b0;
      unique case (state_r)
         cfb8_pkg::ST_FILL: begin
            if (take) begin
               if (fill_cnt_r == 4'h0) begin
                  dec_nxt = dir_decipher_i;
                  rev_nxt = op_reverse_i;
                  tri_nxt = triple_pass_i;
               end
               shift_nxt    = shift_in(shift_r, in_byte_i.data);
               fill_cnt_nxt = fill_cnt_r + 4'h1;
               if (fill_cnt_r == cfb8_pkg::FILL_BYTES - 4'h1) begin
                  pass_nxt  = cfb8_pkg::PASS_SINGLE;
                  state_nxt = cfb8_pkg::ST_RUN;
               end
            end
         end
         cfb8_pkg::ST_RUN: begin
            // pass 0 takes the buffer, later passes the last result
            req_nxt.start    = 1'b1;
            req_nxt.decipher = rev_r ^ pass_r[0];
            req_nxt.key_sel  = pass_r[0];
            req_nxt.block    = (pass_r == cfb8_pkg::PASS_SINGLE) ? shift_r : dreg_r;
            dreg_nxt         = cfb8_pkg::ZERO_BLOCK;
            done_seen_nxt    = 1'b0;
            state_nxt        = cfb8_pkg::ST_WAIT;
         end
         cfb8_pkg::ST_WAIT: begin
            if (eng_done_i) begin
               dreg_nxt      = eng_result_i;
               done_seen_nxt = 1'b1;
               if (tri_r && (pass_r != cfb8_pkg::PASS_TRIPLE)) begin
                  pass_nxt  = pass_r + 2'h1;
                  state_nxt = cfb8_pkg::ST_RUN;
               end else begin
                  state_nxt = cfb8_pkg::ST_KEY;
               end
            end
         end
         cfb8_pkg::ST_KEY: begin
            // first byte read is the key; zeros shift in behind it
            key_nxt   = dreg_r[cfb8_pkg::BLOCK_W-1 -: cfb8_pkg::BYTE_W];
            dreg_nxt  = shift_in(dreg_r, cfb8_pkg::ZERO_BYTE);
            state_nxt = cfb8_pkg::ST_BYTE;
         end
         cfb8_pkg::ST_BYTE: begin
            if (take && in_byte_i.is_fill) begin
               // a fill byte starts a fresh preload
               shift_nxt    = shift_in(shift_r, in_byte_i.data);
               fill_cnt_nxt = 4'h1;
               dec_nxt      = dir_decipher_i;
               rev_nxt      = op_reverse_i;
               tri_nxt      = triple_pass_i;
               state_nxt    = cfb8_pkg::ST_FILL;
            end else if (take) begin
               shift_nxt = shift_in(shift_r, feedback);
               pass_nxt  = cfb8_pkg::PASS_SINGLE;
               state_nxt = cfb8_pkg::ST_RUN;
            end
         end
         default: begin
            state_nxt = cfb8_pkg::ST_FILL;
         end
      endcase
   end

   // sequencer registers
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_r     <= cfb8_pkg::ST_FILL;
         shift_r     <= cfb8_pkg::ZERO_BLOCK;
         dreg_r      <= cfb8_pkg::ZERO_BLOCK;
         key_r       <= cfb8_pkg::ZERO_BYTE;
         fill_cnt_r  <= 4'h0;
         pass_r      <= cfb8_pkg::PASS_SINGLE;
         dec_r       <= 1'b0;
         rev_r       <= 1'b0;
         tri_r       <= 1'b0;
         done_seen_r <= 1'b0;
         req_r       <= '0;
      end else begin
         state_r     <= state_nxt;
         shift_r     <= shift_nxt;
         dreg_r      <= dreg_nxt;
         key_r       <= key_nxt;
         fill_cnt_r  <= fill_cnt_nxt;
         pass_r      <= pass_nxt;
         dec_r       <= dec_nxt;
         rev_r       <= rev_nxt;
         tri_r       <= tri_nxt;
         done_seen_r <= done_seen_nxt;
         req_r       <= req_nxt;
      end
   end

   // ****************************************
   // output buffer
   // ****************************************
   // stall by the receiver holds text input off, no byte lost
   pair_buffer #(.W(cfb8_pkg::BYTE_W)) u_out_buf (
      .sys_clk_i    (sys_clk_i),
      .rstn_i       (rstn_i),
      .push_valid_i (push_valid),
      .push_data_i  (push_data),
      .push_ready_o (push_ready),
      .pop_valid_o  (out_valid_o),
      .pop_data_o   (out_byte_o),
      .pop_ready_i  (out_ready_i)
   );

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);

   // byte into an empty buffer must show at the output next cycle as text xor key
   property p_xor_out;
      (push_valid && !out_valid_o) |=>
         out_valid_o && out_byte_o == $past(in_byte_i.data ^ key_r);
   endproperty
   a_xor_out: assert property (p_xor_out) else $error("output byte is not input xor key");

   property p_fb_shift;
      push_valid |=> shift_r == {$past(shift_r[55:0]), $past(feedback)};
   endproperty
   a_fb_shift: assert property (p_fb_shift) else $error("feedback byte not shifted in");

   property p_rx_shift;
      (push_valid && dec_r) |=> shift_r[7:0] == $past(in_byte_i.data);
   endproperty
   a_rx_shift: assert property (p_rx_shift) else $error("received byte not fed back");

   property p_submit;
      push_valid |=> (state_r == cfb8_pkg::ST_RUN) ##1 (req_r.start && req_r.block == shift_r);
   endproperty
   a_submit: assert property (p_submit) else $error("updated buffer not submitted");

   property p_fill_first;
      req_r.start |-> fill_cnt_r == cfb8_pkg::FILL_BYTES;
   endproperty
   a_fill_first: assert property (p_fill_first) else $error("engine started before fill");

   property p_one_per_op;
      push_valid |=> !push_valid [*3];
   endproperty
   a_one_per_op: assert property (p_one_per_op) else $error("two bytes in one operation");

   property p_wait_done;
      (state_r == cfb8_pkg::ST_KEY) |-> done_seen_r && !busy_o;
   endproperty
   a_wait_done: assert property (p_wait_done) else $error("key read before completion");

   property p_key_byte;
      (state_r == cfb8_pkg::ST_KEY) |=> key_r == $past(dreg_r[63:56]);
   endproperty
   a_key_byte: assert property (p_key_byte) else $error("key is not first byte read");

   property p_zero_shift;
      (state_r == cfb8_pkg::ST_KEY) |=> dreg_r[7:0] == 8'h00 && dreg_r[63:8] == $past(dreg_r[55:0]);
   endproperty
   a_zero_shift: assert property (p_zero_shift) else $error("read did not shift zeros");

   property p_busy_wait;
      (state_r == cfb8_pkg::ST_WAIT && !eng_done_i) |=> busy_o;
   endproperty
   a_busy_wait: assert property (p_busy_wait) else $error("busy dropped before done");

   c_tx_byte:  cover property (push_valid && !dec_r);
   c_rx_byte:  cover property (push_valid && dec_r);
   c_triple:   cover property (req_r.start && pass_r == cfb8_pkg::PASS_TRIPLE);
   c_stall:    cover property ((state_r == cfb8_pkg::ST_BYTE) && !push_ready);
endmodule

// *** cfb8_byte_stream_wrapper_test.sv ***
// file: self-checking testbench for the byte feedback wrapper
`timescale 1ns/1ps
module cfb8_byte_stream_wrapper_test;
   // ****************************************
   // signals and model state
   // ****************************************
   localparam logic [63:0] KEY_A = 64'h0123_4567_89AB_CDEF;
   localparam logic [63:0] KEY_B = 64'hFEDC_BA98_7654_3210;
   logic                sys_clk_i = 1'b0;
   logic                rstn_i = 1'b0;
   logic                dir_decipher_i = 1'b0;
   logic                op_reverse_i = 1'b0;
   logic                triple_pass_i = 1'b0;
   logic                in_valid_i = 1'b0;
   cfb8_pkg::byte_in_t  in_byte_i = '0;
   logic                out_ready_i = 1'b0;
   logic                in_ready_o, out_valid_o, busy_o, fill_done_o, eng_done_i;
   logic [7:0]          out_byte_o;
   cfb8_pkg::eng_req_t  eng_req_o;
   logic [63:0]         eng_result_i;
   logic [8:0]          delay_r = 9'h000;
   int                  errors = 0;
   int                  check_count = 0;
   int                  starts = 0;
   int                  rx_n = 0;
   bit                  hold = 1'b0;
   logic [63:0]         buf_m;
   logic [7:0]          key_m;
   logic [7:0]          fillv [8];
   logic [7:0]          exp_q[$], cip_q[$], pl_q[$];

   // clock
   initial begin
      forever #50 sys_clk_i = ~sys_clk_i;
   end

   cfb8_byte_stream_wrapper DUT (
      .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .dir_decipher_i(dir_decipher_i),
      .op_reverse_i(op_reverse_i), .triple_pass_i(triple_pass_i), .in_valid_i(in_valid_i),
      .in_byte_i(in_byte_i), .in_ready_o(in_ready_o), .out_valid_o(out_valid_o),
      .out_byte_o(out_byte_o), .out_ready_i(out_ready_i), .eng_req_o(eng_req_o),
      .eng_done_i(eng_done_i), .eng_result_i(eng_result_i), .busy_o(busy_o),
      .fill_done_o(fill_done_o));

   cfb8_engine_model #(.KEY_A(KEY_A), .KEY_B(KEY_B)) engine (
      .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .req_i(eng_req_o), .delay_i(delay_r),
      .done_o(eng_done_i), .result_o(eng_result_i));

   // ****************************************
   // reference model and helpers
   // ****************************************
   function automatic logic [63:0] ref_op(input logic [63:0] b, input logic dec, input logic ks);
      return ({b[54:0], b[63:55]} + (ks ? KEY_B : KEY_A)) ^ {8{dec, 7'h35}};
   endfunction

   // key byte is the top byte of the final pass
   function automatic logic [7:0] key_of(input logic [63:0] b);
      logic [63:0] r;
      r = ref_op(b, op_reverse_i, 1'b0);
      if (triple_pass_i) r = ref_op(ref_op(r, ~op_reverse_i, 1'b1), op_reverse_i, 1'b0);
      return r[63:56];
   endfunction

   task automatic end_of_test();
      $display("errors=%0d checks=%0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input bit ok, input string msg);
      check_count++;
      if (!ok) begin
         errors++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask

   // holds valid up; caller lowers it after the last byte
   task automatic offer(input logic fill, input logic [7:0] d, input int lim, output bit taken);
      in_valid_i = 1'b1;
      in_byte_i  = '{fill, d};
      taken      = 1'b0;
      for (int i = 0; i < lim && !taken; i++) begin
         @(posedge sys_clk_i);
         taken = (in_ready_o === 1'b1);
         #1;
      end
   endtask

   task automatic send(input logic [7:0] d);
      bit t;
      offer(1'b0, d, 800, t);
      chk(t, "text byte not taken");
      if (!t) end_of_test();
      exp_q.push_back(d ^ key_m);
      buf_m = {buf_m[55:0], (dir_decipher_i ? d : d ^ key_m)};
      key_m = key_of(buf_m);
   endtask

   // one full stream: reset (fill byte restart for receive with reverse), preload, bytes, drain
   task automatic run(input logic dec, input logic rev, input logic tri3, input bit stall);
      bit t;
      int k;
      in_valid_i = 1'b0;
      dir_decipher_i = dec;
      op_reverse_i = rev;
      triple_pass_i = tri3;
      exp_q.delete();
      rx_n = 0;
      hold = stall;
      if (!dec) cip_q.delete();
      // receive runs with reverse restart by a fill byte, the rest by reset
      if (!dec || !rev) begin
         rstn_i = 1'b0;
         repeat (6) @(posedge sys_clk_i);
         #1 rstn_i = 1'b1;
      end else begin
         @(posedge sys_clk_i);
         #1;
      end
      for (int i = 0; i < 8; i++) begin
         offer(1'b1, fillv[i], 50, t);
         chk(t, "fill byte not taken");
         if (!t) end_of_test();
         buf_m = {buf_m[55:0], fillv[i]};
      end
      chk(fill_done_o === 1'b1, "preload not done after eight bytes");
      key_m = key_of(buf_m);
      for (int i = 0; i < 12; i++) begin
         if (i == 2 && stall) begin
            offer(1'b0, pl_q[i], 300, t);
            chk(!t, "byte taken while output full");
            hold = 1'b0;
         end
         send(dec ? cip_q[i] : pl_q[i]);
      end
      in_valid_i = 1'b0;
      for (k = 0; k < 3000 && !(exp_q.size() == 0 && busy_o === 1'b0 && in_ready_o === 1'b1);
           k++) @(posedge sys_clk_i);
      #1;
      chk(k < 3000, "stream did not drain");
      if (k >= 3000) end_of_test();
      chk(starts === 13 * (tri3 ? 3 : 1), "engine operations per byte");
      starts = 0;
   endtask

   // ****************************************
   // output collector and random stalls
   // ****************************************
   always @(posedge sys_clk_i) begin
      logic [7:0] e;
      if (out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
         chk(exp_q.size() > 0, "unexpected output byte");
         if (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            chk(out_byte_o === e, "output byte mismatch");
            if (dir_decipher_i) chk(out_byte_o === pl_q[rx_n++], "round trip mismatch");
            else cip_q.push_back(e);
         end
      end
      if (eng_req_o.start === 1'b1) starts++;
      if (eng_done_i === 1'b1) chk(busy_o === 1'b1, "busy low during engine op");
      #1;
      out_ready_i = hold ? 1'b0 : 1'($urandom % 4 != 0);
      delay_r = ($urandom % 4 == 0) ? 9'h09F : 9'($urandom % 8);
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      void'($urandom(32'h14d5979d));
      for (int i = 0; i < 8; i++) fillv[i] = 8'($urandom);
      for (int m = 0; m < 4; m++) begin
         pl_q.delete();
         for (int i = 0; i < 12; i++) pl_q.push_back(8'($urandom));
         run(1'b0, m[0], m[1], (m == 0));
         run(1'b1, m[0], m[1], 1'b0);
      end
      end_of_test();
   end
endmodule

// *** cfb8_engine_model.sv ***
// file: behavioural block cipher engine on the far side of the byte wrapper
`timescale 1ns/1ps
module cfb8_engine_model #(
   parameter logic [63:0] KEY_A = 64'h0123_4567_89AB_CDEF,
   parameter logic [63:0] KEY_B = 64'hFEDC_BA98_7654_3210
) (
   // clock and reset
   input  wire logic                         sys_clk_i,
   input  wire logic                         rstn_i,
   // request from the wrapper
   input  wire cfb8_pkg::eng_req_t           req_i,
   input  wire logic [8:0]                   delay_i,
   // answer to the wrapper
   output logic                              done_o,
   output logic [cfb8_pkg::BLOCK_W-1:0]      result_o
);
   // ****************************************
   // block operation and timing
   // ****************************************
   logic [63:0] res_r;
   logic [8:0]  cnt_r;
   logic        run_r;

   // stand-in cipher: key pair picks the key, direction flag alters the mix
   function automatic logic [63:0] blk_op(input logic [63:0] b, input logic dec, input logic ks);
      return ({b[54:0], b[63:55]} + (ks ? KEY_B : KEY_A)) ^ {8{dec, 7'h35}};
   endfunction

   // latch on start, count out the delay, pulse done with the result
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         run_r    <= 1'b0;
         cnt_r    <= 9'h000;
         res_r    <= 64'h0;
         done_o   <= 1'b0;
         result_o <= 64'h0;
      end else begin
         done_o   <= 1'b0;
         result_o <= ~result_o;  // stale data inverted each idle cycle
         if (req_i.start) begin
            run_r    <= 1'b1;
            cnt_r    <= delay_i;
            res_r    <= blk_op(req_i.block, req_i.decipher, req_i.key_sel);
            result_o <= cfb8_pkg::ZERO_BLOCK;
         end else if (run_r && cnt_r == 9'h000) begin
            run_r    <= 1'b0;
            done_o   <= 1'b1;
            result_o <= res_r;
         end else if (run_r) begin
            cnt_r    <= cnt_r - 9'h001;
            result_o <= cfb8_pkg::ZERO_BLOCK;
         end
      end
   end
endmodule

// *** cfb8_pkg.sv ***
// package: shared constants and carriers for the byte feedback wrapper
package cfb8_pkg;
   // ****************************************
   // sizes and timing
   // ****************************************
   localparam int          BYTE_W          = 8;
   localparam int          BLOCK_W         = 64;
   localparam logic [3:0]  FILL_BYTES      = 4'h8;
   localparam int          SYS_PERIOD_NS   = 100;
   localparam int          DBL_PERIOD_NS   = 50;
   localparam int          ENG_OP_DBL_CYC  = 320;
   localparam int          ENG_OP_SYS_CYC  = (ENG_OP_DBL_CYC * DBL_PERIOD_NS) / SYS_PERIOD_NS;
   localparam logic [1:0]  PASS_SINGLE     = 2'h0;
   localparam logic [1:0]  PASS_TRIPLE     = 2'h2;
   localparam logic [BYTE_W-1:0]  ZERO_BYTE  = 8'h00;
   localparam logic [BLOCK_W-1:0] ZERO_BLOCK = 64'h0000_0000_0000_0000;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic              is_fill;
      logic [BYTE_W-1:0] data;
   } byte_in_t;

   typedef struct packed {
      logic               start;
      logic               decipher;
      logic               key_sel;
      logic [BLOCK_W-1:0] block;
   } eng_req_t;

   typedef enum logic [2:0] {
      ST_FILL = 3'h0,
      ST_RUN  = 3'h1,
      ST_WAIT = 3'h3,
      ST_KEY  = 3'h2,
      ST_BYTE = 3'h6
   } state_t;
endpackage

// *** pair_buffer.sv ***
// module: two entry valid/ready buffer for output bytes
`timescale 1ns/1ps
module pair_buffer #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         sys_clk_i,
   input  wire logic         rstn_i,
   // fill side
   input  wire logic         push_valid_i,
   input  wire logic [W-1:0] push_data_i,
   output logic              push_ready_o,
   // drain side
   output logic              pop_valid_o,
   output logic [W-1:0]      pop_data_o,
   input  wire logic         pop_ready_i
);
   logic [W-1:0] mem_r [2];
   logic [W-1:0] mem_nxt [2];
   logic         wr_r, wr_nxt, rd_r, rd_nxt;
   logic [1:0]   cnt_r, cnt_nxt;
   logic         do_push, do_pop;

   // handshakes
   assign push_ready_o = (cnt_r != 2'h2);
   assign pop_valid_o  = (cnt_r != 2'h0);
   assign pop_data_o   = mem_r[rd_r];
   assign do_push      = push_valid_i && push_ready_o;
   assign do_pop       = pop_valid_o && pop_ready_i;

   // next pointers and storage
   always_comb begin
      mem_nxt = mem_r;
      wr_nxt  = wr_r;
      rd_nxt  = rd_r;
      cnt_nxt = cnt_r;
      if (do_push) begin
         mem_nxt[wr_r] = push_data_i;
         wr_nxt        = ~wr_r;
      end
      if (do_pop) begin
         rd_nxt = ~rd_r;
      end
      if (do_push && !do_pop) begin
         cnt_nxt = cnt_r + 2'h1;
      end else if (!do_push && do_pop) begin
         cnt_nxt = cnt_r - 2'h1;
      end
   end

   // registers
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mem_r[0] <= '0;
         mem_r[1] <= '0;
         wr_r     <= 1'b0;
         rd_r     <= 1'b0;
         cnt_r    <= 2'h0;
      end else begin
         mem_r <= mem_nxt;
         wr_r  <= wr_nxt;
         rd_r  <= rd_nxt;
         cnt_r <= cnt_nxt;
      end
   end
endmodule
